/* common/aof_defines.vh */
/*
 * Constants for the converter output stage: word width, pipeline depth,
 * power-down exit recovery and the settle window after a format change.
 * Assumes a single 100 MHz conversion clock.
 */
`ifndef AOF_DEFINES_VH
`define AOF_DEFINES_VH

// ----------------------------------------------------------------------
// Data path
// ----------------------------------------------------------------------
`define AOF_WORD_W 12
`define AOF_PIPE_DEPTH 6
`define AOF_WORD_RST 12'h000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define AOF_CLK_PERIOD_NS 10
`define AOF_EXIT_TIME_NS 1000
`define AOF_EXIT_CYCLES ((`AOF_EXIT_TIME_NS + `AOF_CLK_PERIOD_NS - 1) / `AOF_CLK_PERIOD_NS)
`define AOF_FMT_SETTLE_CYCLES 12'h006
`define AOF_CNT_W 12

`endif

/* hw/aof_pipe.v */
/*
 * Sample delay line: one word in per clock, the same word out a fixed
 * number of clocks later, each stage a flip-flop.
 * Assumes the caller supplies the flush strobe for power-down.
 */
`timescale 1ns/100ps
`include "aof_defines.vh"

module aof_pipe (
    // Clock and reset
    input wire i_mclk,
    input wire i_arst_n,
    // Control
    input wire i_flush,
    // Data
    input wire [`AOF_WORD_W-1:0] i_word,
    output wire [`AOF_WORD_W-1:0] o_word
);

    genvar g;
    generate
        for (g = 0; g < `AOF_PIPE_DEPTH; g = g + 1) begin : g_stage
            reg [`AOF_WORD_W-1:0] word;
            wire [`AOF_WORD_W-1:0] word_in;
            // First stage takes the sample, the rest the stage before
            if (g == 0) begin : g_head
                assign word_in = i_word;
            end else begin : g_tail
                assign word_in = g_stage[g-1].word;
            end
            always @(posedge i_mclk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    word <= `AOF_WORD_RST;
                end else if (i_flush) begin
                    word <= `AOF_WORD_RST;
                end else begin
                    word <= word_in;
                end
            end
        end
    endgenerate

    assign o_word = g_stage[`AOF_PIPE_DEPTH-1].word;

endmodule

/* hw/aof_core.v */
/*
 * Output and control side of a 12-bit pipelined converter: takes one
 * raw offset binary sample per clock, delays it seven clocks, codes it
 * as offset binary or two's complement, and handles power-down with
 * an exit recovery period. Valid flag marks usable words.
 * Assumes a continuous conversion clock and static control inputs
 * synchronous to it; the capturing logic latches on the rising edge.
 * Undefined power-down words are shown as zero so that the capturing
 * side never sees a stale sample; it must still honour the valid flag.
 * A format change costs a few invalid words rather than a mixed-code
 * word: the settle window covers the words already in the pipe.
 * The clock must keep running; recovery is counted in clock cycles.
 */
// Function
// - Select high gives two's complement words, low gives offset binary.
// - Words after a select change are unreliable and flagged invalid a while.
// - Power-down input high keeps the block idle regardless of clock; the code reaches ST_DOWN and flushes the pipe only on a clock edge.
// - In power-down outputs are undefined and pipeline contents are discarded.
// - Valid results are driven only while power-down input is low.
// - Each result leaves as a 12-bit parallel word, one bit per line.
// - After power-down ends, words are invalid until the recovery time passes.
// - The clock samples the input and steps the sequencing state machine.
// - Each sample appears on the output seven clocks after it was taken.
// - One new word leaves per clock period.
`timescale 1ns/100ps
`include "aof_defines.vh"

module aof_core (
    // Clock and reset
    input wire i_mclk,
    input wire i_arst_n,
    // Static controls
    input wire i_format_select,
    input wire i_power_down_input,
    // Raw quantiser sample, offset binary
    input wire [`AOF_WORD_W-1:0] i_sample,
    // Parallel output
    output reg [`AOF_WORD_W-1:0] o_data,
    output wire o_data_valid,
    output wire o_powered_down
);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    localparam [1:0] ST_DOWN = 2'b00;
    localparam [1:0] ST_RECOVER = 2'b01;
    localparam [1:0] ST_FILL = 2'b10;
    localparam [1:0] ST_RUN = 2'b11;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`AOF_CNT_W-1:0] count;
    reg [`AOF_CNT_W-1:0] next_count;
    reg [`AOF_CNT_W-1:0] fmt_hold;
    reg fmt_last;
    reg sample_reg;
    wire [`AOF_WORD_W-1:0] sample_in;
    wire [`AOF_WORD_W-1:0] delayed;
    reg [`AOF_WORD_W-1:0] next_data;
    reg [`AOF_CNT_W-1:0] next_fmt_hold;
    wire recover_done;
    wire fill_done;
    wire fmt_changed;
    wire fmt_steady;
    wire in_run;

    // ------------------------------------------------------------------
    // Sequencer end points
    // ------------------------------------------------------------------
    // Wait-state counts run from zero
    assign recover_done = (count == `AOF_EXIT_CYCLES - 1);
    assign fill_done = (count == `AOF_PIPE_DEPTH - 1);

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_DOWN;
            count <= {`AOF_CNT_W{1'b0}};
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    always @* begin
        next_state = state;
        next_count = count;
        if (i_power_down_input) begin
            next_state = ST_DOWN;
            next_count = {`AOF_CNT_W{1'b0}};
        end else begin
            case (state)
                ST_DOWN: begin
                    next_state = ST_RECOVER;
                    next_count = {`AOF_CNT_W{1'b0}};
                end
                ST_RECOVER: begin
                    if (recover_done) begin
                        next_state = ST_FILL;
                        next_count = {`AOF_CNT_W{1'b0}};
                    end else begin
                        next_count = count + 1'b1;
                    end
                end
                ST_FILL: begin
                    if (fill_done) begin
                        next_state = ST_RUN;
                        next_count = {`AOF_CNT_W{1'b0}};
                    end else begin
                        next_count = count + 1'b1;
                    end
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_DOWN;
                    next_count = {`AOF_CNT_W{1'b0}};
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sampling and pipeline
    // ------------------------------------------------------------------
    // Qualifies valid one clock behind power-down
    // Sample on rising edge
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= ~i_power_down_input;
        end
    end

    assign sample_in = i_power_down_input ? `AOF_WORD_RST : i_sample;

    aof_pipe u_pipe (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_flush(i_power_down_input),
        .i_word(sample_in),
        .o_word(delayed)
    );

    // ------------------------------------------------------------------
    // Format select settle window
    // ------------------------------------------------------------------
    // Invalid after select change
    assign fmt_changed = (fmt_last != i_format_select);

    always @* begin
        next_fmt_hold = fmt_hold;
        if (fmt_changed) begin
            next_fmt_hold = `AOF_FMT_SETTLE_CYCLES;
        end else if (fmt_hold != {`AOF_CNT_W{1'b0}}) begin
            next_fmt_hold = fmt_hold - 1'b1;
        end
    end

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fmt_last <= 1'b0;
            fmt_hold <= {`AOF_CNT_W{1'b0}};
        end else begin
            fmt_last <= i_format_select;
            fmt_hold <= next_fmt_hold;
        end
    end

    assign fmt_steady = (fmt_hold == {`AOF_CNT_W{1'b0}});

    // ------------------------------------------------------------------
    // Output coding
    // ------------------------------------------------------------------
    always @* begin
        next_data = delayed;
        case ({i_power_down_input, i_format_select})
            2'b00: begin
                next_data = delayed;
            end
            2'b01: begin
                next_data = {~delayed[`AOF_WORD_W-1], delayed[`AOF_WORD_W-2:0]};
            end
            default: begin
                next_data = `AOF_WORD_RST;
            end
        endcase
    end

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_data <= `AOF_WORD_RST;
        end else begin
            o_data <= next_data;
        end
    end

    // ------------------------------------------------------------------
    // Valid qualification
    // ------------------------------------------------------------------
    // Recovered and refilled
    assign in_run = (state == ST_RUN) && sample_reg;

    assign o_data_valid = in_run && !i_power_down_input && fmt_steady;
    // Low-power indication straight from the state register
    assign o_powered_down = (state == ST_DOWN);

endmodule

/* sim/aof_monitor.sv */
/* Port checker for aof_core.
   Assumes format and power-down stay put through each recovery. */
`timescale 1ns/100ps
`include "aof_defines.vh"
module aof_monitor (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_format_select,
    input wire i_power_down_input,
    input wire [`AOF_WORD_W-1:0] i_sample,
    input wire [`AOF_WORD_W-1:0] o_data,
    input wire o_data_valid,
    input wire o_powered_down
);
    localparam int WAKE_MAX = 120;
    logic [7:0] cnt;
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n)
            cnt <= 8'h00;
        else if (i_power_down_input)
            cnt <= 8'h00;
        else if (cnt != 8'hff)
            cnt <= cnt + 8'h01;
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    sequence s_settle; !o_data_valid [*6]; endsequence
    sequence s_wake; ##[1:WAKE_MAX] o_data_valid; endsequence
    a_pd_no_valid: assert property (i_power_down_input |-> !o_data_valid ##1 !o_data_valid)
        else $error("valid during power-down");
    a_pd_data_zero: assert property ($past(i_power_down_input) |-> o_data == 12'h000)
        else $error("data not cleared in power-down");
    a_pd_state: assert property ($past(i_power_down_input) |-> o_powered_down)
        else $error("not idle in power-down");
    a_exit_hold: assert property (o_data_valid |-> cnt > 8'h64)
        else $error("valid before recovery ended");
    a_exit_wake: assert property ($fell(o_powered_down) |-> s_wake)
        else $error("no valid word after recovery");
    a_fmt_settle: assert property ($changed(i_format_select) |-> ##1 s_settle)
        else $error("valid right after format change");
    a_data_latency: assert property (o_data_valid |->
        o_data == ($past(i_sample, 7) ^ {$past(i_format_select), 11'h000}))
        else $error("wrong word or delay");
    a_run_state: assert property (o_data_valid |->
        !o_powered_down && !$past(o_powered_down, 8))
        else $error("valid while idle");
endmodule
bind aof_core aof_monitor i_mon (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_format_select(i_format_select), .i_power_down_input(i_power_down_input),
    .i_sample(i_sample), .o_data(o_data), .o_data_valid(o_data_valid),
    .o_powered_down(o_powered_down));

/* sim/aof_capture.sv */
/* Capturing logic on the far side of the converter.
   Assumes the same conversion clock as the converter. */
`timescale 1ns/100ps
`include "aof_defines.vh"
module aof_capture (
    // Clock
    input wire i_mclk,
    // Converter words
    input wire [`AOF_WORD_W-1:0] i_data,
    input wire i_data_valid,
    // Captured word
    output reg [`AOF_WORD_W-1:0] o_word,
    output reg o_strobe
);
    initial o_strobe = 1'b0;
    always @(posedge i_mclk) begin
        o_strobe <= i_data_valid;
        if (i_data_valid)
            o_word <= i_data;
    end
endmodule

/* sim/aof_core_tb_top.sv */
/* Bench for aof_core: random samples, format and power-down steps.
   Assumes the capture model and the bound checker. */
`timescale 1ns/100ps
`include "aof_defines.vh"
module aof_core_tb_top;
    reg i_mclk, i_arst_n, i_format_select, i_power_down_input;
    reg [`AOF_WORD_W-1:0] i_sample;
    wire [`AOF_WORD_W-1:0] o_data, cap_word;
    wire o_data_valid, o_powered_down, cap_strobe;
    int miscompares, total_checks;
    reg [12:0] q[$];
    reg [12:0] e;
    aof_core i_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_format_select(i_format_select),
        .i_power_down_input(i_power_down_input), .i_sample(i_sample), .o_data(o_data),
        .o_data_valid(o_data_valid), .o_powered_down(o_powered_down));
    aof_capture i_cap (.i_mclk(i_mclk), .i_data(o_data), .i_data_valid(o_data_valid),
        .o_word(cap_word), .o_strobe(cap_strobe));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // ----------------------------------------------------------------
    // Model and compares
    // ----------------------------------------------------------------
    always @(posedge i_mclk) begin
        q.push_back({i_format_select, i_sample});
        if (q.size() > 8)
            q.pop_front();
    end
    always @(negedge i_mclk) begin
        if (cap_strobe === 1'b1 && q.size() == 8) begin
            e = q[0];
            check_word({e[12] ^ e[11], e[10:0]}, cap_word);
        end
    end
    task check_word(input [`AOF_WORD_W-1:0] exp, input [`AOF_WORD_W-1:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task check_flag(input exp, input got);
        check_word({11'h000, exp}, {11'h000, got});
    endtask
    task end_sim;
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task run(input int n, input f, input p);
        reg [31:0] rnd;
        repeat (n) begin
            @(posedge i_mclk);
            rnd = $urandom;
            i_format_select <= f;
            i_power_down_input <= p;
            i_sample <= rnd[`AOF_WORD_W-1:0];
        end
        #1;
    endtask
    initial begin
        i_arst_n = 1'b0;
        i_format_select = 1'b0;
        i_power_down_input = 1'b0;
        i_sample = 12'h000;
        void'($urandom(36052));
        repeat (16) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        run(200, 1'b0, 1'b0);
        check_flag(1'b1, o_data_valid);
        run(4, 1'b1, 1'b0);
        check_flag(1'b0, o_data_valid);
        run(200, 1'b1, 1'b0);
        run(30, 1'b1, 1'b1);
        check_flag(1'b1, o_powered_down);
        check_flag(1'b0, o_data_valid);
        check_word(12'h000, o_data);
        run(50, 1'b0, 1'b0);
        check_flag(1'b0, o_data_valid);
        run(150, 1'b0, 1'b0);
        check_flag(1'b1, o_data_valid);
        end_sim;
    end
    initial begin
        #50000;
        miscompares++;
        end_sim;
    end
endmodule
